/* File: datapath_mode_fast_detect_regs.sv */
// register bank and light datapath: output mode, decimation, offset, fast-detect pins
// assumes samples arrive synchronous to mclk with one common valid for all channels
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module datapath_mode_fast_detect_regs #(
  parameter int NUM_CHAN = dp_fd_pkg::NUM_CHAN
) (
  // clock and reset
  input  wire logic                            mclk,
  input  wire logic                            reset,
  // register port
  input  wire logic [dp_fd_pkg::ADDR_W-1:0]    addr,
  input  wire logic [dp_fd_pkg::DATA_W-1:0]    wrData,
  input  wire logic                            wrStb,
  input  wire logic                            rdStb,
  output logic      [dp_fd_pkg::DATA_W-1:0]    rdData,
  // sample input
  input  wire logic                            sampleValid,
  input  dp_fd_pkg::sample_s                   sampleIn   [NUM_CHAN],
  // sample output
  output logic                                 outValid,
  output logic                                 quadValid,
  output dp_fd_pkg::sample_s                   outSample  [NUM_CHAN],
  // mode outputs
  output logic      [1:0]                      ddcEnable,
  // fast-detect pins
  output logic      [NUM_CHAN-1:0]             overrangeFlagPin
);
  import dp_fd_pkg::*;

  function automatic logic [1:0] ddcMask(input logic [3:0] mode);
    case (mode)
      APP_ONE_DDC: ddcMask = 2'h1;
      APP_TWO_DDC: ddcMask = 2'h3;
      default:     ddcMask = 2'h0;
    endcase
  endfunction : ddcMask

  function automatic logic [3:0] decimLimit(input logic [2:0] code);
    if (code > DECIM_MAX) begin
      decimLimit = 4'h0;
    end else begin
      decimLimit = 4'((5'h01 << code) - 5'h01);
    end
  endfunction : decimLimit

  function automatic logic chanHit(input logic [ADDR_W-1:0] a, input int c);
    chanHit = (a[ADDR_W-1 -: CH_IDX_W] == CH_IDX_W'(c));
  endfunction : chanHit

  function automatic logic [13:0] satAdd(input logic signed [13:0] s,
                                         input logic        [7:0]  o);
    logic signed [14:0] sum;
    sum = 15'(s) + 15'(signed'(o));
    if (sum > 15'sh1FFF) begin
      satAdd = 14'h1FFF;
    end else if (sum < -15'sh2000) begin
      satAdd = 14'h2000;
    end else begin
      satAdd = sum[13:0];
    end
  endfunction : satAdd

  // chip-wide registers
  logic [7:0]             appSel_r;
  logic [7:0]             appSel_nxt;
  logic [7:0]             decim_r;
  logic [7:0]             decim_nxt;
  logic [DECIM_CNT_W-1:0] decimCnt_r;
  logic [DECIM_CNT_W-1:0] decimCnt_nxt;
  logic                   outValid_r;
  logic                   outValid_nxt;
  logic                   quadValid_r;
  logic                   quadValid_nxt;
  logic [1:0]             ddcEnable_r;
  logic [1:0]             ddcEnable_nxt;
  logic [7:0]             rdData_r;
  logic [7:0]             rdData_nxt;
  logic                   decimHit;
  logic                   qIgnore;
  logic [OFF_W-1:0]       offs;

  // per-channel state
  chan_cfg_s              cfg_r      [NUM_CHAN];
  chan_cfg_s              cfg_nxt    [NUM_CHAN];
  logic [NUM_CHAN-1:0]    flag_r;
  logic [NUM_CHAN-1:0]    flag_nxt;
  logic [NUM_CHAN-1:0]    pin_r;
  logic [NUM_CHAN-1:0]    pin_nxt;
  logic [DWELL_W-1:0]     dwell_r    [NUM_CHAN];
  logic [DWELL_W-1:0]     dwell_nxt  [NUM_CHAN];
  logic [MAG_W-1:0]       mag        [NUM_CHAN];
  sample_s                out_r      [NUM_CHAN];
  sample_s                out_nxt    [NUM_CHAN];

  assign offs     = addr[OFF_W-1:0];
  assign qIgnore  = appSel_r[QIGNORE_BIT];
  assign decimHit = sampleValid && (decimCnt_r == '0);

  // chip-wide registers, decimation counter and mode outputs
  always_comb begin
    appSel_nxt    = appSel_r;
    decim_nxt     = decim_r;
    decimCnt_nxt  = decimCnt_r;
    if (wrStb && offs == OFF_APP_SEL) begin
      appSel_nxt = wrData & APP_SEL_MASK;
    end
    if (wrStb && offs == OFF_DECIM) begin
      decim_nxt = wrData & DECIM_MASK;
    end
    // a ratio lowered mid-run wraps at once rather than counting past it
    if (sampleValid) begin
      if (decimCnt_r >= decimLimit(decim_r[2:0])) begin
        decimCnt_nxt = '0;
      end else begin
        decimCnt_nxt = decimCnt_r + 4'h1;
      end
    end
    outValid_nxt  = decimHit;
    quadValid_nxt = decimHit && !qIgnore;
    ddcEnable_nxt = ddcMask(appSel_r[3:0]);
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdData_nxt = RST_BYTE;
    if (rdStb) begin
      case (offs)
        OFF_APP_SEL:   rdData_nxt = appSel_r;
        OFF_DECIM:     rdData_nxt = decim_r;
        OFF_OFFSET:    rdData_nxt = cfg_r[addr[ADDR_W-1 -: CH_IDX_W]].offsetAdj;
        OFF_FD_CTRL:   rdData_nxt = cfg_r[addr[ADDR_W-1 -: CH_IDX_W]].fdCtrl;
        OFF_UP_LO:     rdData_nxt = cfg_r[addr[ADDR_W-1 -: CH_IDX_W]].upper[7:0];
        OFF_UP_HI:     rdData_nxt = {3'h0, cfg_r[addr[ADDR_W-1 -: CH_IDX_W]].upper[12:8]};
        OFF_LOW_LO:    rdData_nxt = cfg_r[addr[ADDR_W-1 -: CH_IDX_W]].lower[7:0];
        OFF_LOW_HI:    rdData_nxt = {3'h0, cfg_r[addr[ADDR_W-1 -: CH_IDX_W]].lower[12:8]};
        OFF_DWELL_LO:  rdData_nxt = cfg_r[addr[ADDR_W-1 -: CH_IDX_W]].dwell[7:0];
        OFF_DWELL_HI:  rdData_nxt = cfg_r[addr[ADDR_W-1 -: CH_IDX_W]].dwell[15:8];
        OFF_FD_STATUS: rdData_nxt = 8'(flag_r);
        default:       rdData_nxt = RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      appSel_r    <= RST_BYTE;
      decim_r     <= RST_BYTE;
      decimCnt_r  <= '0;
      outValid_r  <= 1'b0;
      quadValid_r <= 1'b0;
      ddcEnable_r <= 2'h0;
      rdData_r    <= RST_BYTE;
    end else begin
      appSel_r    <= appSel_nxt;
      decim_r     <= decim_nxt;
      decimCnt_r  <= decimCnt_nxt;
      outValid_r  <= outValid_nxt;
      quadValid_r <= quadValid_nxt;
      ddcEnable_r <= ddcEnable_nxt;
      rdData_r    <= rdData_nxt;
    end
  end

  genvar c;
  generate
    for (c = 0; c < NUM_CHAN; c++) begin : g_chan
      // abs of a 14-bit sample, top 13 bits form the fine magnitude
      logic [SAMPLE_W-1:0] absVal;
      assign absVal = sampleIn[c].i[SAMPLE_W-1] ? SAMPLE_W'(-sampleIn[c].i)
                                                 : SAMPLE_W'(sampleIn[c].i);
      assign mag[c] = absVal[SAMPLE_W-1:1];

      always_comb begin
        cfg_nxt[c] = cfg_r[c];
        if (wrStb && chanHit(addr, c)) begin
          case (offs)
            OFF_OFFSET:   cfg_nxt[c].offsetAdj  = wrData;
            OFF_FD_CTRL:  cfg_nxt[c].fdCtrl     = wrData & FD_CTRL_MASK;
            OFF_UP_LO:    cfg_nxt[c].upper[7:0] = wrData;
            OFF_UP_HI:    cfg_nxt[c].upper[12:8] = wrData[4:0];
            OFF_LOW_LO:   cfg_nxt[c].lower[7:0] = wrData;
            OFF_LOW_HI:   cfg_nxt[c].lower[12:8] = wrData[4:0];
            OFF_DWELL_LO: cfg_nxt[c].dwell[7:0] = wrData;
            OFF_DWELL_HI: cfg_nxt[c].dwell[15:8] = wrData;
            default:      cfg_nxt[c] = cfg_r[c];
          endcase
        end
      end

      // fast-detect flag with dwell hold-off
      always_comb begin
        flag_nxt[c]  = flag_r[c];
        dwell_nxt[c] = dwell_r[c];
        if (!cfg_r[c].fdCtrl[FD_EN_BIT]) begin
          flag_nxt[c]  = 1'b0;
          dwell_nxt[c] = '0;
        end else if (sampleValid) begin
          if (mag[c] > cfg_r[c].upper) begin
            flag_nxt[c]  = 1'b1;
            dwell_nxt[c] = cfg_r[c].dwell;
          end else if (flag_r[c]) begin
            if (mag[c] >= cfg_r[c].lower) begin
              dwell_nxt[c] = cfg_r[c].dwell;
            end else if (dwell_r[c] == '0) begin
              flag_nxt[c] = 1'b0;
            end else begin
              dwell_nxt[c] = dwell_r[c] - 16'h0001;
            end
          end
        end
        // forcing bypasses detection but leaves its state running
        if (cfg_r[c].fdCtrl[FD_FORCE_BIT]) begin
          pin_nxt[c] = cfg_r[c].fdCtrl[FD_VALUE_BIT];
        end else begin
          pin_nxt[c] = flag_nxt[c];
        end
      end

      // offset applied to I, and to Q unless Q is ignored (then Q is zero), saturating instead of wrapping
      always_comb begin
        out_nxt[c] = out_r[c];
        if (decimHit) begin
          out_nxt[c].i = satAdd(sampleIn[c].i, cfg_r[c].offsetAdj);
          out_nxt[c].q = qIgnore ? 14'h0000
                                 : satAdd(sampleIn[c].q, cfg_r[c].offsetAdj);
        end
      end

      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          cfg_r[c]   <= CHAN_CFG_RST;
          flag_r[c]  <= 1'b0;
          pin_r[c]   <= 1'b0;
          dwell_r[c] <= '0;
          out_r[c]   <= '0;
        end else begin
          cfg_r[c]   <= cfg_nxt[c];
          flag_r[c]  <= flag_nxt[c];
          pin_r[c]   <= pin_nxt[c];
          dwell_r[c] <= dwell_nxt[c];
          out_r[c]   <= out_nxt[c];
        end
      end

      assign outSample[c] = out_r[c];
    end
  endgenerate

  assign rdData           = rdData_r;
  assign outValid         = outValid_r;
  assign quadValid        = quadValid_r;
  assign ddcEnable        = ddcEnable_r;
  assign overrangeFlagPin = pin_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  AST_Q_IGNORED: assert property (
    outValid_r && $past(qIgnore) |-> !quadValid_r && outSample[0].q == 14'h0000)
    else $error("quadrature output while ignored");

  AST_APP_TWO: assert property (
    appSel_r[3:0] == APP_TWO_DDC ##1 $stable(appSel_r) |-> ddcEnable_r == 2'h3)
    else $error("two downconverter mode not applied");

  AST_DECIM_FULL: assert property (
    decim_r[2:0] == 3'h0 && decimCnt_r == '0 && sampleValid |=> outValid_r)
    else $error("full rate sample not passed");

  AST_DECIM_BY16: assert property (
    decim_r[2:0] == DECIM_MAX && decimCnt_r == 4'h1 && sampleValid |->
      decimCnt_nxt == 4'h2 && !decimHit)
    else $error("decimate by sixteen counter wrong");

  // only away from full scale, where a plain sum and the saturating sum agree
  AST_OFFSET_ADD: assert property (
    decimHit && sampleIn[0].i < 14'sh1F40 && sampleIn[0].i > -14'sh1F40 |=>
      out_r[0].i == 14'($past(sampleIn[0].i) + 14'(signed'($past(cfg_r[0].offsetAdj)))))
    else $error("offset not added");

  AST_FORCE_PIN: assert property (
    cfg_r[2].fdCtrl[FD_FORCE_BIT] |=> pin_r[2] == $past(cfg_r[2].fdCtrl[FD_VALUE_BIT]))
    else $error("forced pin value wrong");

  AST_FORCE_HOLD: assert property (
    cfg_r[2].fdCtrl[FD_FORCE_BIT] && !cfg_r[2].fdCtrl[FD_VALUE_BIT] [*2] |->
      !pin_r[2])
    else $error("forced low pin went high");

  AST_FD_DISABLED: assert property (
    !cfg_r[0].fdCtrl[FD_EN_BIT] && !cfg_r[0].fdCtrl[FD_FORCE_BIT] |=> !pin_r[0])
    else $error("disabled detector drove pin");

  AST_FD_SET: assert property (
    cfg_r[2].fdCtrl[FD_EN_BIT] && !cfg_r[2].fdCtrl[FD_FORCE_BIT] && sampleValid &&
      mag[2] > cfg_r[2].upper |=> pin_r[2] && flag_r[2])
    else $error("pin not set above upper threshold");

  AST_FD_RISE_CAUSE: assert property (
    $rose(flag_r[2]) |-> $past(mag[2] > cfg_r[2].upper))
    else $error("flag rose without threshold crossing");

  AST_DWELL_HOLD: assert property (
    flag_r[2] && dwell_r[2] != '0 && $stable(cfg_r[2].fdCtrl) |=> flag_r[2])
    else $error("flag cleared before dwell expired");

  COV_FD_CLEAR: cover property (
    flag_r[2] && cfg_r[2].fdCtrl[FD_EN_BIT] ##1 !flag_r[2]);
  COV_FORCED_HIGH: cover property (
    cfg_r[2].fdCtrl[FD_FORCE_BIT] && cfg_r[2].fdCtrl[FD_VALUE_BIT] ##1 pin_r[2]);
  COV_DECIM8_OUT: cover property (decim_r[2:0] == 3'h3 && outValid_r);
  COV_REAL_ONLY: cover property (outValid_r && !quadValid_r);
endmodule : datapath_mode_fast_detect_regs

/* File: dp_fd_pkg.sv */
// constants and carriers for the datapath mode and fast-detect register bank
// assumes a single register clock domain and byte-wide register data
package dp_fd_pkg;
  localparam int           NUM_CHAN      = 4;
  localparam int           ADDR_W        = 12;
  localparam int           DATA_W        = 8;
  localparam int           CH_IDX_W      = 2;
  localparam int           OFF_W         = 10;
  localparam int           SAMPLE_W      = 14;
  localparam int           MAG_W         = 13;
  localparam int           DWELL_W       = 16;
  localparam int           DECIM_CNT_W   = 4;

  localparam logic [9:0]   OFF_APP_SEL   = 10'h200;
  localparam logic [9:0]   OFF_DECIM     = 10'h201;
  localparam logic [9:0]   OFF_OFFSET    = 10'h228;
  localparam logic [9:0]   OFF_FD_CTRL   = 10'h245;
  localparam logic [9:0]   OFF_UP_LO     = 10'h247;
  localparam logic [9:0]   OFF_UP_HI     = 10'h248;
  localparam logic [9:0]   OFF_LOW_LO    = 10'h249;
  localparam logic [9:0]   OFF_LOW_HI    = 10'h24A;
  localparam logic [9:0]   OFF_DWELL_LO  = 10'h24B;
  localparam logic [9:0]   OFF_DWELL_HI  = 10'h24C;
  localparam logic [9:0]   OFF_FD_STATUS = 10'h2F0;

  localparam int           QIGNORE_BIT   = 5;
  localparam int           FD_FORCE_BIT  = 3;
  localparam int           FD_VALUE_BIT  = 2;
  localparam int           FD_EN_BIT     = 0;
  localparam logic [7:0]   APP_SEL_MASK  = 8'h2F;
  localparam logic [7:0]   FD_CTRL_MASK  = 8'h0D;
  localparam logic [7:0]   DECIM_MASK    = 8'h07;

  localparam logic [3:0]   APP_FULL      = 4'h0;
  localparam logic [3:0]   APP_ONE_DDC   = 4'h1;
  localparam logic [3:0]   APP_TWO_DDC   = 4'h2;
  localparam logic [2:0]   DECIM_MAX     = 3'h4;

  localparam logic [7:0]   RST_BYTE      = 8'h00;

  typedef struct packed {
    logic        [7:0]  offsetAdj;
    logic        [7:0]  fdCtrl;
    logic        [12:0] upper;
    logic        [12:0] lower;
    logic        [15:0] dwell;
  } chan_cfg_s;

  typedef struct packed {
    logic signed [13:0] i;
    logic signed [13:0] q;
  } sample_s;

  localparam chan_cfg_s    CHAN_CFG_RST  = '0;
endpackage : dp_fd_pkg

/* File: tb_top.sv */
// self-checking bench for the datapath mode and fast-detect register bank
// assumes the bench drives every port itself; all channels see the same sample stream
`timescale 1ns/1ps
module tb_top;
  import dp_fd_pkg::*;

  typedef struct packed {
    logic [11:0] a;
    logic [7:0]  w;
    logic [7:0]  e;
  } row_s;

  logic                  mclk;
  logic                  reset;
  logic [ADDR_W-1:0]     addr;
  logic [DATA_W-1:0]     wrData;
  logic                  wrStb;
  logic                  rdStb;
  logic [DATA_W-1:0]     rdData;
  logic                  sampleValid;
  sample_s               sampleIn  [NUM_CHAN];
  logic                  outValid;
  logic                  quadValid;
  sample_s               outSample [NUM_CHAN];
  logic [1:0]            ddcEnable;
  logic [NUM_CHAN-1:0]   overrangeFlagPin;
  int                    nErrors;
  int                    totalChecks;
  int                    nOut;
  logic [7:0]            rv;
  row_s                  rows      [7];

  datapath_mode_fast_detect_regs i_dut (
    .mclk(mclk), .reset(reset), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData(rdData), .sampleValid(sampleValid), .sampleIn(sampleIn),
    .outValid(outValid), .quadValid(quadValid), .outSample(outSample),
    .ddcEnable(ddcEnable), .overrangeFlagPin(overrangeFlagPin)
  );

  always #50 mclk = ~mclk;

  always @(posedge mclk) begin
    if (outValid === 1'b1) nOut = nOut + 1;
  end

  function automatic logic [11:0] ad(input int ch, input logic [9:0] off);
    return {ch[1:0], off};
  endfunction : ad

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("ERROR at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d, mismatches %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'b1;
    @(posedge mclk);
    wrStb  <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge mclk);
    rdStb <= 1'b0;
    #1;
    d = rdData;
  endtask : rd

  // one valid sample on every channel; outputs are looked at in the cycle after
  task automatic send(input logic signed [13:0] iv, input logic signed [13:0] qv);
    @(posedge mclk);
    foreach (sampleIn[c]) sampleIn[c] <= {iv, qv};
    sampleValid <= 1'b1;
    @(posedge mclk);
    sampleValid <= 1'b0;
    #1;
  endtask : send

  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge mclk);
    nErrors++;
    close_out();
  end

  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    addr = '0;
    wrData = '0;
    wrStb = 1'b0;
    rdStb = 1'b0;
    sampleValid = 1'b0;
    foreach (sampleIn[c]) sampleIn[c] = '0;
    nErrors = 0;
    totalChecks = 0;
    nOut = 0;
    // reserved bits drop out of the readback; unmapped offset reads zero
    rows = '{'{ad(0, OFF_APP_SEL), 8'hFF, 8'h2F}, '{ad(0, OFF_DECIM), 8'hFF, 8'h07},
             '{ad(1, OFF_OFFSET), 8'h80, 8'h80}, '{ad(0, OFF_FD_CTRL), 8'hFF, 8'h0D},
             '{ad(0, OFF_UP_LO), 8'h55, 8'h55}, '{ad(0, OFF_UP_HI), 8'hFF, 8'h1F},
             '{ad(0, 10'h3FF), 8'hAA, 8'h00}};
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    #1;
    chk(16'(overrangeFlagPin), 16'h0000);
    foreach (rows[k]) begin
      rd(rows[k].a, rv);
      chk(16'(rv), 16'h0000);
      wr(rows[k].a, rows[k].w);
      rd(rows[k].a, rv);
      chk(16'(rv), 16'(rows[k].e));
    end
    // application modes, unlisted code falls back to full bandwidth
    for (int m = 0; m < 4; m++) begin
      wr(ad(0, OFF_APP_SEL), 8'(m));
      settle();
      chk(16'(ddcEnable), (m == 1) ? 16'h0001 : (m == 2) ? 16'h0003 : 16'h0000);
    end
    wr(ad(0, OFF_APP_SEL), 8'h00);
    // 32 samples divide evenly for every ratio, so counter phase does not matter
    // code 5 is outside the table and must behave as full rate
    for (int d = 0; d < 6; d++) begin
      wr(ad(0, OFF_DECIM), 8'(d));
      #1;
      nOut = 0;
      repeat (32) begin
        @(posedge mclk);
        sampleValid <= 1'b1;
      end
      @(posedge mclk);
      sampleValid <= 1'b0;
      settle();
      chk(16'(nOut), (d > 4) ? 16'h0020 : 16'(32 >> d));
    end
    wr(ad(0, OFF_DECIM), 8'h00);
    // offsets: positive limit, negative limit, saturation at full scale
    wr(ad(0, OFF_OFFSET), 8'h7F);
    send(14'sd100, -14'sd5);
    chk(16'(outSample[0].i), 16'(14'sd227));
    chk(16'(outSample[0].q), 16'(14'sd122));
    chk(16'(outSample[1].i), 16'(-14'sd28));
    chk(16'(quadValid), 16'h0001);
    send(14'sd8191, 14'sd0);
    chk(16'(outSample[0].i), 16'(14'sd8191));
    wr(ad(0, OFF_APP_SEL), 8'h20);
    send(14'sd10, 14'sd10);
    chk(16'({outValid, quadValid}), 16'h0002);
    chk(16'(outSample[1].q), 16'h0000);
    wr(ad(0, OFF_APP_SEL), 8'h00);
    // channel 2: upper 256 needs the high byte, lower 16, dwell 2
    wr(ad(2, OFF_UP_LO), 8'h00);
    wr(ad(2, OFF_UP_HI), 8'h01);
    wr(ad(2, OFF_LOW_LO), 8'h10);
    wr(ad(2, OFF_DWELL_LO), 8'h02);
    wr(ad(2, OFF_FD_CTRL), 8'h01);
    send(14'sd513, 14'sd0);
    chk(16'(overrangeFlagPin[2]), 16'h0000);
    send(-14'sd600, 14'sd0);
    // channel 0 is still forced high by the row test
    chk(16'(overrangeFlagPin), 16'h0005);
    rd(ad(0, OFF_FD_STATUS), rv);
    chk(16'(rv), 16'h0004);
    send(14'sd0, 14'sd0);
    send(14'sd0, 14'sd0);
    chk(16'(overrangeFlagPin[2]), 16'h0001);
    send(14'sd0, 14'sd0);
    chk(16'(overrangeFlagPin[2]), 16'h0000);
    // forcing wins over a disabled detector, both levels
    wr(ad(2, OFF_FD_CTRL), 8'h0C);
    settle();
    chk(16'(overrangeFlagPin[2]), 16'h0001);
    wr(ad(2, OFF_FD_CTRL), 8'h08);
    settle();
    chk(16'(overrangeFlagPin[2]), 16'h0000);
    wr(ad(2, OFF_FD_CTRL), 8'h00);
    send(14'sd2000, 14'sd0);
    chk(16'(overrangeFlagPin[2]), 16'h0000);
    // second reset in mid-run clears the bank
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd(ad(0, OFF_OFFSET), rv);
    chk(16'(rv), 16'h0000);
    chk(16'(overrangeFlagPin), 16'h0000);
    close_out();
  end
endmodule : tb_top
